/* File: design/sdp_pkg.sv */
// Constants shared by the debug port system access register block.
// Assumes a 64 MHz port logic clock and an 8-bit register access path.
package sdp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_RESET_REQUEST = 4'h8;
    localparam logic [3:0] OFS_CLOCK_SELECT = 4'h9;
    localparam logic [3:0] OFS_SYSTEM_CONTROL = 4'hA;
    localparam logic [3:0] OFS_SYSTEM_STATUS = 4'hB;
    localparam logic [3:0] OFS_CRC_STATUS = 4'hC;
    localparam logic [3:0] OFS_KEY_STATUS = 4'h7;

    // ------------------------------------------------------------
    // Codes, reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_CODE_ASSERT = 8'h59;
    localparam logic [7:0] RESET_CODE_RELEASE = 8'h00;
    localparam logic [1:0] CLKSEL_RESERVED = 2'h0;
    localparam logic [1:0] CLKSEL_16MHZ = 2'h1;
    localparam logic [1:0] CLKSEL_8MHZ = 2'h2;
    localparam logic [1:0] CLKSEL_4MHZ = 2'h3;
    localparam logic [1:0] CLKSEL_RESET = 2'h3;
    localparam logic [7:0] STATUS_RESET = 8'h01;
    localparam int BIT_CLOCK_REQUEST = 0;
    localparam int BIT_USER_ROW_COMMIT = 1;
    localparam int BIT_LOCKED = 0;
    localparam int BIT_USER_ROW_READY = 2;
    localparam int BIT_MEMORY_READY = 3;
    localparam int BIT_ASLEEP = 4;
    localparam int BIT_RESET_ACTIVE = 5;
    localparam int BIT_KEY_USER_ROW = 5;
    localparam logic [2:0] CRC_DISABLED = 3'h0;
    localparam logic [2:0] CRC_BUSY = 3'h1;
    localparam logic [2:0] CRC_GOOD = 3'h2;
    localparam logic [2:0] CRC_FAILED = 3'h4;

    // ------------------------------------------------------------
    // Port clock divider: half period in clk cycles, minus one
    // ------------------------------------------------------------
    localparam logic [3:0] DIV_16MHZ = 4'h1;
    localparam logic [3:0] DIV_8MHZ = 4'h3;
    localparam logic [3:0] DIV_4MHZ = 4'h7;
endpackage : sdp_pkg

/* File: design/sdp_clk_div.sv */
// Port clock generator: toggles a divided port clock at the chosen rate.
// Assumes a fast source clock; each toggle ends a half period of the port clock.
`timescale 1ns/1ps
`default_nettype none
module sdp_clk_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Control
    input wire logic [1:0] sel_i,
    // Output
    output logic port_clk_o
);
    logic [3:0] cnt_q;
    logic [3:0] lim;
    logic port_clk_q;

    always_comb begin
        case (sel_i)
            sdp_pkg::CLKSEL_16MHZ: lim = sdp_pkg::DIV_16MHZ;
            sdp_pkg::CLKSEL_8MHZ: lim = sdp_pkg::DIV_8MHZ;
            // Reserved code falls back to the safe slow rate
            default: lim = sdp_pkg::DIV_4MHZ;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 4'h0;
            port_clk_q <= 1'b0;
        end else if (ce_i) begin
            if (cnt_q >= lim) begin
                cnt_q <= 4'h0;
                port_clk_q <= ~port_clk_q;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    assign port_clk_o = port_clk_q;
endmodule : sdp_clk_div
`default_nettype wire

/* File: design/sdp_regs.sv */
// System access registers of the single-wire debug port.
// Assumes the port instruction layer drives wr/rd strobes for one cycle
// and that system status inputs arrive asynchronously from system domain.
//
// How it works
// - Writing 0x59 asserts system reset; writing 0x00 releases it.
// - Requested system reset never resets this port logic.
// - Clock select codes 1,2,3 give 16, 8, 4 MHz; 0 reserved.
// - Clock select holds 3 after reset and after port enable.
// - Writing one to control bit 1 starts user-row commit to flash.
// - Commit bit is writable only after user-row key decoded.
// - Commit before data in RAM programs no user-row content.
// - Control bit 0 holds system clock request regardless of sleep.
// - Clock request clears whenever port is disabled.
// - Clock request sets when port enabled in programming mode.
// - Status bit 5 shows system reset active.
// - Reading system status clears reset-active bit.
// - Requested reset also shows in reset-active bit.
// - Status bit 4 shows system in idle or deeper sleep.
// - Status bit 3 shows memory programming may begin.
// - Status bit 2 shows user-row programming may begin.
// - Status bit 0 shows locked; resets to one, zero after erase.
// - CRC status field is one-hot: 0 off, 1 busy, 2 good, 4 bad.
// - Key status bit 5 sets once user-row key decoded.
`timescale 1ns/1ps
`default_nettype none
module sdp_regs #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Port state
    input wire logic port_enable_i,
    input wire logic prog_mode_i,
    input wire logic user_row_key_ok_i,
    // Register access
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // System domain status, asynchronous
    input wire logic sys_in_reset_i,
    input wire logic sys_asleep_i,
    input wire logic nvm_prog_ready_i,
    input wire logic urow_prog_ready_i,
    input wire logic sys_locked_i,
    input wire logic [2:0] crc_state_i,
    input wire logic urow_data_in_ram_i,
    // Controls to system
    output logic sys_reset_req_o,
    output logic sys_clock_req_o,
    output logic user_row_commit_o,
    output logic port_clk_o
);
    // Offsets of this block need four address bits
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("ADDR_W must be at least 4");
    end

    // ------------------------------------------------------------
    // Synchronisers for system status
    // ------------------------------------------------------------
    localparam int SW = 8;
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic [SW-1:0] raw;
    assign raw = {urow_data_in_ram_i, sys_in_reset_i, sys_asleep_i,
                  nvm_prog_ready_i, urow_prog_ready_i, sys_locked_i,
                  1'b0, 1'b0};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= 8'h01 << 2;
            sync_q <= 8'h01 << 2;
        end else if (ce_i) begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end
    logic s_ram, s_rst, s_sleep, s_nvm, s_urow, s_lock;
    assign s_ram = sync_q[7];
    assign s_rst = sync_q[6];
    assign s_sleep = sync_q[5];
    assign s_nvm = sync_q[4];
    assign s_urow = sync_q[3];
    assign s_lock = sync_q[2];

    logic [2:0] crc_meta_q;
    logic [2:0] crc_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crc_meta_q <= sdp_pkg::CRC_DISABLED;
            crc_q <= sdp_pkg::CRC_DISABLED;
        end else if (ce_i) begin
            crc_meta_q <= crc_state_i;
            crc_q <= crc_meta_q;
        end
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    logic wr_rst, wr_sel, wr_ctl, rd_stat;
    assign wr_rst = ce_i && wr_i && hit(addr_i, sdp_pkg::OFS_RESET_REQUEST);
    assign wr_sel = ce_i && wr_i && hit(addr_i, sdp_pkg::OFS_CLOCK_SELECT);
    assign wr_ctl = ce_i && wr_i && hit(addr_i, sdp_pkg::OFS_SYSTEM_CONTROL);
    assign rd_stat = ce_i && rd_i && hit(addr_i, sdp_pkg::OFS_SYSTEM_STATUS);

    // Port enable edge, same clock domain
    logic en_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) en_q <= 1'b0;
        else if (ce_i) en_q <= port_enable_i;
    end
    logic en_rise;
    assign en_rise = port_enable_i && !en_q;

    // ------------------------------------------------------------
    // Reset request register
    // ------------------------------------------------------------
    // Only rst_b_i, port disable and a 0x00 write clear it; the system reset driven
    // from here never reaches this logic.
    logic [7:0] reset_req_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reset_req_q <= sdp_pkg::RESET_CODE_RELEASE;
        end else if (ce_i) begin
            if (!port_enable_i) begin
                reset_req_q <= sdp_pkg::RESET_CODE_RELEASE;
            end else if (wr_rst && (wdata_i == sdp_pkg::RESET_CODE_ASSERT
                         || wdata_i == sdp_pkg::RESET_CODE_RELEASE)) begin
                reset_req_q <= wdata_i;
            end
        end
    end
    assign sys_reset_req_o = (reset_req_q == sdp_pkg::RESET_CODE_ASSERT);

    // ------------------------------------------------------------
    // Clock select register
    // ------------------------------------------------------------
    logic [1:0] clk_sel_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_sel_q <= sdp_pkg::CLKSEL_RESET;
        end else if (ce_i) begin
            if (!port_enable_i || en_rise) begin
                clk_sel_q <= sdp_pkg::CLKSEL_RESET;
            end else if (wr_sel) begin
                clk_sel_q <= wdata_i[1:0];
            end
        end
    end

    sdp_clk_div u_div (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .sel_i(clk_sel_q),
        .port_clk_o(port_clk_o)
    );

    // ------------------------------------------------------------
    // System control register
    // ------------------------------------------------------------
    logic clk_req_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_req_q <= 1'b0;
        end else if (ce_i) begin
            if (!port_enable_i) begin
                clk_req_q <= 1'b0;
            end else if (en_rise && prog_mode_i) begin
                clk_req_q <= 1'b1;
            end else if (wr_ctl) begin
                clk_req_q <= wdata_i[sdp_pkg::BIT_CLOCK_REQUEST];
            end
        end
    end
    assign sys_clock_req_o = clk_req_q;

    // One-cycle commit pulse, only with key and with data already in RAM
    logic commit_q;
    logic commit_wr;
    assign commit_wr = wr_ctl && port_enable_i && user_row_key_ok_i
                       && wdata_i[sdp_pkg::BIT_USER_ROW_COMMIT];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) commit_q <= 1'b0;
        else if (ce_i) commit_q <= commit_wr && s_ram;
    end
    assign user_row_commit_o = commit_q;

    // ------------------------------------------------------------
    // System status: sticky reset-active, cleared on read
    // ------------------------------------------------------------
    logic rst_seen_q;
    logic rst_now;
    assign rst_now = s_rst || sys_reset_req_o;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_seen_q <= 1'b0;
        end else if (ce_i) begin
            if (rst_now) rst_seen_q <= 1'b1; // Set wins over read clear
            else if (rd_stat) rst_seen_q <= 1'b0;
        end
    end

    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[sdp_pkg::BIT_RESET_ACTIVE] = rst_seen_q;
        status[sdp_pkg::BIT_ASLEEP] = s_sleep;
        status[sdp_pkg::BIT_MEMORY_READY] = s_nvm;
        status[sdp_pkg::BIT_USER_ROW_READY] = s_urow;
        status[sdp_pkg::BIT_LOCKED] = s_lock;
    end

    // ------------------------------------------------------------
    // Read data, registered
    // ------------------------------------------------------------
    logic [7:0] rdata_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i && rd_i) begin
            if (hit(addr_i, sdp_pkg::OFS_RESET_REQUEST))
                rdata_q <= reset_req_q;
            else if (hit(addr_i, sdp_pkg::OFS_CLOCK_SELECT))
                rdata_q <= {6'h00, clk_sel_q};
            else if (hit(addr_i, sdp_pkg::OFS_SYSTEM_CONTROL))
                rdata_q <= {7'h00, clk_req_q};
            else if (hit(addr_i, sdp_pkg::OFS_SYSTEM_STATUS))
                rdata_q <= status;
            else if (hit(addr_i, sdp_pkg::OFS_CRC_STATUS))
                rdata_q <= {5'h00, crc_q};
            else if (hit(addr_i, sdp_pkg::OFS_KEY_STATUS))
                rdata_q <= 8'(user_row_key_ok_i)
                           << sdp_pkg::BIT_KEY_USER_ROW;
            else
                rdata_q <= 8'h00;
        end
    end
    assign rdata_o = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_RESET_ASSERT: assert property (
        wr_rst && port_enable_i && wdata_i == sdp_pkg::RESET_CODE_ASSERT
        |=> sys_reset_req_o)
        else $error("reset code did not raise system reset");
    AST_RESET_RELEASE: assert property (
        wr_rst && port_enable_i && wdata_i == sdp_pkg::RESET_CODE_RELEASE
        |=> !sys_reset_req_o)
        else $error("release code did not drop system reset");
    AST_RESERVED_KEEP: assert property (
        wr_rst && wdata_i != sdp_pkg::RESET_CODE_ASSERT
        && wdata_i != sdp_pkg::RESET_CODE_RELEASE && port_enable_i
        |=> $stable(sys_reset_req_o))
        else $error("reserved code changed reset state");
    AST_SEL_DEFAULT: assert property (
        en_rise && ce_i |=> clk_sel_q == sdp_pkg::CLKSEL_4MHZ)
        else $error("clock select not default after enable");
    AST_SYSTEM_CLOCK_REQUEST_OFF: assert property (
        !port_enable_i && ce_i |=> !sys_clock_req_o)
        else $error("clock request kept while disabled");
    AST_SYSTEM_CLOCK_REQUEST_ON: assert property (
        en_rise && prog_mode_i && ce_i |=> sys_clock_req_o)
        else $error("clock request not set on programming entry");
    AST_COMMIT_KEY: assert property (
        user_row_commit_o && $past(ce_i)
        |-> $past(user_row_key_ok_i) && $past(wr_ctl))
        else $error("commit without key");
    AST_RST_STICKY: assert property (
        sys_reset_req_o && ce_i |=> status[sdp_pkg::BIT_RESET_ACTIVE])
        else $error("requested reset not shown in status");
    AST_RD_CLEAR: assert property (
        rd_stat && !rst_now |=> !rst_seen_q)
        else $error("status read did not clear reset bit");
    AST_COMMIT_RAM: assert property (
        user_row_commit_o && $past(ce_i) |-> $past(s_ram))
        else $error("commit without user-row data in RAM");
    AST_SYSTEM_CLOCK_REQUEST_WRITE: assert property (
        wr_ctl && port_enable_i && !(en_rise && prog_mode_i)
        |=> sys_clock_req_o == $past(wdata_i[sdp_pkg::BIT_CLOCK_REQUEST]))
        else $error("clock request did not follow control write");

    COV_RESET: cover property (wr_rst ##1 sys_reset_req_o);
    COV_COMMIT: cover property (user_row_commit_o);
    COV_FAST: cover property (clk_sel_q == sdp_pkg::CLKSEL_16MHZ);
    COV_PROG_ENTRY: cover property (
        en_rise && prog_mode_i ##1 sys_clock_req_o);
endmodule : sdp_regs
`default_nettype wire

/* File: tb/sdp_sys_model.sv */
// System domain stand-in for the register block's bench.
// Assumes the reset request is a level that the system follows.
`timescale 1ns/1ps
`default_nettype none
module sdp_sys_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Request from the port
    input wire logic reset_req_i,
    // Status to the port
    output logic in_reset_o
);
    // One cycle late, as a real reset tree would be
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_reset_o <= 1'b0;
        end else begin
            in_reset_o <= reset_req_i;
        end
    end
endmodule : sdp_sys_model
`default_nettype wire

/* File: tb/sdp_regs_tb_top.sv */
// Self-checking bench for the system access register block.
// Assumes registers answer one cycle after a read strobe.
`timescale 1ns/1ps
`default_nettype none
module sdp_regs_tb_top;
    logic clk, rst_b, ce, port_en, prog_mode, key_ok, wr, rd;
    logic asleep, nvm_rdy, urow_rdy, locked, in_ram, in_reset;
    logic rst_req, clk_req, commit, port_clk;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [2:0] crc;
    int fails, total_checks, cycles, n;

    sdp_regs #(.ADDR_W(4)) dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
        .port_enable_i(port_en), .prog_mode_i(prog_mode),
        .user_row_key_ok_i(key_ok), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .rdata_o(rdata), .sys_in_reset_i(in_reset),
        .sys_asleep_i(asleep), .nvm_prog_ready_i(nvm_rdy),
        .urow_prog_ready_i(urow_rdy), .sys_locked_i(locked),
        .crc_state_i(crc), .urow_data_in_ram_i(in_ram),
        .sys_reset_req_o(rst_req), .sys_clock_req_o(clk_req),
        .user_row_commit_o(commit), .port_clk_o(port_clk));

    sdp_sys_model sys (.clk_i(clk), .rst_b_i(rst_b),
        .reset_req_i(rst_req), .in_reset_o(in_reset));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask : wr_reg

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check8(rdata, exp);
        @(negedge clk);
    endtask : chk_reg

    // Half period of the port clock in system clock cycles
    task automatic half_period(output int cnt);
        logic v;
        cnt = 0;
        v = port_clk;
        while (port_clk === v && cnt < 20) begin
            @(negedge clk);
        end
        v = port_clk;
        while (port_clk === v && cnt < 20) begin
            @(negedge clk);
            cnt++;
        end
    endtask : half_period

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_defaults;
        chk_reg(4'h8, 8'h00);
        chk_reg(4'h9, 8'h03);
        chk_reg(4'hA, 8'h00);
        chk_reg(4'hB, 8'h01);
        chk_reg(4'hC, 8'h00);
        chk_reg(4'hF, 8'h00);
        check8({5'h00, rst_req, clk_req, commit}, 8'h00);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_clksel;
        logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        int exp [4] = '{2, 4, 8, 8};
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'h9, {6'h00, sel[i]});
            chk_reg(4'h9, {6'h00, sel[i]});
            half_period(n);
            half_period(n);
            check8(8'(n), 8'(exp[i]));
        end
        $display("test clock select done");
    endtask : t_clksel

    task automatic t_reset;
        wr_reg(4'h9, 8'h02);
        wr_reg(4'h8, 8'h59);
        check8({7'h00, rst_req}, 8'h01);
        wr_reg(4'h8, 8'h33);
        check8({7'h00, rst_req}, 8'h01);
        repeat (4) @(negedge clk);
        chk_reg(4'hB, 8'h21);
        chk_reg(4'h9, 8'h02);
        wr_reg(4'h8, 8'h00);
        check8({7'h00, rst_req}, 8'h00);
        repeat (8) @(negedge clk);
        chk_reg(4'hB, 8'h21);
        chk_reg(4'hB, 8'h01);
        wr_reg(4'h9, 8'h03);
        $display("test reset request done");
    endtask : t_reset

    task automatic t_control;
        logic [2:0] cases [3] = '{3'b010, 3'b100, 3'b111};
        wr_reg(4'hA, 8'h01);
        asleep = 1'b1;
        repeat (4) @(negedge clk);
        check8({7'h00, clk_req}, 8'h01);
        chk_reg(4'hB, 8'h11);
        asleep = 1'b0;
        wr_reg(4'hA, 8'h00);
        check8({7'h00, clk_req}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            key_ok = cases[i][2];
            in_ram = cases[i][1];
            repeat (4) @(negedge clk);
            chk_reg(4'h7, {2'h0, key_ok, 5'h00});
            addr = 4'hA;
            wdata = 8'h02;
            wr = 1'b1;
            n = 0;
            repeat (4) begin
                @(negedge clk);
                wr = 1'b0;
                n += (commit === 1'b1) ? 1 : ((commit === 1'b0) ? 0 : 16);
            end
            check8(8'(n), {7'h00, cases[i][0]});
        end
        key_ok = 1'b0;
        $display("test control done");
    endtask : t_control

    task automatic t_status;
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        locked = 1'b0;
        nvm_rdy = 1'b1;
        urow_rdy = 1'b1;
        for (int i = 0; i < 4; i++) begin
            crc = codes[i];
            repeat (4) @(negedge clk);
            chk_reg(4'hC, {5'h00, codes[i]});
        end
        chk_reg(4'hB, 8'h0C);
        locked = 1'b1;
        nvm_rdy = 1'b0;
        urow_rdy = 1'b0;
        $display("test status done");
    endtask : t_status

    task automatic t_disable;
        wr_reg(4'h9, 8'h01);
        wr_reg(4'hA, 8'h01);
        port_en = 1'b0;
        repeat (3) @(negedge clk);
        check8({7'h00, clk_req}, 8'h00);
        wr_reg(4'hA, 8'h01);
        check8({7'h00, clk_req}, 8'h00);
        chk_reg(4'h9, 8'h03);
        prog_mode = 1'b1;
        port_en = 1'b1;
        repeat (3) @(negedge clk);
        check8({7'h00, clk_req}, 8'h01);
        chk_reg(4'h9, 8'h03);
        $display("test disable done");
    endtask : t_disable

    task automatic t_freeze;
        ce = 1'b0;
        wr_reg(4'hA, 8'h00);
        check8({7'h00, clk_req}, 8'h01);
        ce = 1'b1;
        wr_reg(4'hA, 8'h00);
        check8({7'h00, clk_req}, 8'h00);
        $display("test clock enable done");
    endtask : t_freeze

    // Whole run is well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, 1, 0);
            conclude();
        end
    end

    initial begin
        {rst_b, ce, port_en, prog_mode, key_ok, wr, rd} = 7'b0110000;
        {asleep, nvm_rdy, urow_rdy, locked, in_ram} = 5'b00010;
        addr = 4'h0;
        wdata = 8'h00;
        crc = 3'h0;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_defaults();
        t_clksel();
        t_reset();
        t_control();
        t_status();
        t_disable();
        t_freeze();
        conclude();
    end
endmodule : sdp_regs_tb_top
`default_nettype wire
